// ===== hdl/pnfcs_pkg.sv
// Package for the parallel NOR flash command sequencer host controller
package pnfcs_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned ADDR_W          = 16;
  localparam int unsigned DATA_W          = 16;
  // Strobe widths kept well above the device noise filter
  localparam int unsigned GLITCH_NS       = 15;
  localparam int unsigned STROBE_NS       = 50;
  localparam int unsigned STROBE_CYC      = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_CYC       = 1;
  localparam int unsigned READ_CYC        = 3;
  localparam int unsigned POLL_LIMIT      = 1000000;
  localparam logic [15:0] ADR_UNLK1       = 16'h5555;
  localparam logic [15:0] ADR_UNLK2       = 16'h2AAA;
  localparam logic [15:0] ADR_LOCK_STAT   = 16'h0002;
  localparam logic [15:0] BOOT_LAST       = 16'h1FFF;
  localparam logic [15:0] ERASED_WORD     = 16'hFFFF;
  localparam logic [7:0]  CD_UNLK1        = 8'hAA;
  localparam logic [7:0]  CD_UNLK2        = 8'h55;
  localparam logic [7:0]  CD_PROG         = 8'hA0;
  localparam logic [7:0]  CD_ID_ENTRY     = 8'h90;
  localparam logic [7:0]  CD_ERASE_PRE    = 8'h80;
  localparam logic [7:0]  CD_CHIP         = 8'h10;
  localparam logic [7:0]  CD_MAIN         = 8'h30;
  localparam logic [7:0]  CD_LOCK         = 8'h40;
  localparam logic [7:0]  CD_ID_EXIT      = 8'hF0;
  localparam int unsigned POLL_BIT        = 7;
  localparam int unsigned TOGGLE_BIT      = 6;
  localparam int unsigned LOCK_BIT        = 0;
  localparam int unsigned SEQ_MAX         = 6;

  typedef enum logic [2:0] {
    PNF_READ     = 3'h0,
    PNF_PROGRAM  = 3'h1,
    PNF_CHIP_ER  = 3'h2,
    PNF_MAIN_ER  = 3'h3,
    PNF_LOCKOUT  = 3'h4,
    PNF_ID_ENTRY = 3'h5,
    PNF_ID_EXIT  = 3'h6,
    PNF_ID_EXIT1 = 3'h7
  } pnfcs_op_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_STRB  = 3'b011,
    ST_HOLD  = 3'b010,
    ST_RDSET = 3'b110,
    ST_RDSMP = 3'b111,
    ST_DONE  = 3'b101
  } pnfcs_st_e;

  typedef struct packed {
    pnfcs_op_e          op;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  data;
  } pnfcs_req_s;

  typedef struct packed {
    logic               ce_n;
    logic               oe_n;
    logic               we_n;
    logic               d_oe;
    logic [ADDR_W-1:0]  a;
    logic [DATA_W-1:0]  dq;
  } pnfcs_pins_s;
endpackage : pnfcs_pkg

// ===== hdl/pnfcs_seq_rom.sv
// Command sequence table: address and code for each bus cycle of each operation
`timescale 1ns/1ps
module pnfcs_seq_rom
  import pnfcs_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        CE_I,
  input  wire pnfcs_op_e   OP_I,
  input  wire logic [2:0]  IDX_I,
  output logic [2:0]       LEN_O,
  output logic [15:0]      ADDR_O,
  output logic [7:0]       CODE_O,
  output logic             USER_O
);
  logic [2:0]  len_c;
  logic [15:0] addr_c;
  logic [7:0]  code_c;
  logic        user_c;
  logic [7:0]  last_c;

  always_comb begin
    len_c  = 3'h6;
    last_c = CD_CHIP;
    case (OP_I)
      PNF_PROGRAM:  begin len_c = 3'h4; last_c = CD_PROG;     end
      PNF_CHIP_ER:  begin len_c = 3'h6; last_c = CD_CHIP;     end
      PNF_MAIN_ER:  begin len_c = 3'h6; last_c = CD_MAIN;     end
      PNF_LOCKOUT:  begin len_c = 3'h6; last_c = CD_LOCK;     end
      PNF_ID_ENTRY: begin len_c = 3'h3; last_c = CD_ID_ENTRY; end
      PNF_ID_EXIT:  begin len_c = 3'h3; last_c = CD_ID_EXIT;  end
      PNF_ID_EXIT1: begin len_c = 3'h1; last_c = CD_ID_EXIT;  end
      default:      begin len_c = 3'h0; last_c = CD_ID_EXIT;  end
    endcase
    user_c = 1'b0;
    addr_c = ADR_UNLK1;
    code_c = CD_UNLK1;
    case (IDX_I)
      3'h0: begin addr_c = ADR_UNLK1; code_c = CD_UNLK1; end
      3'h1: begin addr_c = ADR_UNLK2; code_c = CD_UNLK2; end
      3'h2: begin addr_c = ADR_UNLK1; code_c = (len_c == 3'h6) ? CD_ERASE_PRE : last_c; end
      3'h3: begin addr_c = ADR_UNLK1; code_c = CD_UNLK1; user_c = (OP_I == PNF_PROGRAM); end
      3'h4: begin addr_c = ADR_UNLK2; code_c = CD_UNLK2; end
      default: begin addr_c = ADR_UNLK1; code_c = last_c; end
    endcase
    // single-cycle exit op for the user
    // Single-cycle exit may use any address; the user address is sent
    if (OP_I == PNF_ID_EXIT1) begin
      user_c = 1'b1;
      code_c = CD_ID_EXIT;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (CE_I) begin
      LEN_O  <= len_c;
      ADDR_O <= addr_c;
      CODE_O <= code_c;
      USER_O <= user_c;
    end
  end
endmodule : pnfcs_seq_rom

// ===== hdl/pnfcs_ctrl.sv
// Host controller driving a parallel NOR flash through its strobe pins
//
// Contract
// - Main erase is six writes ending with 30 at 5555.
// - Lockout is enabled by a six-write sequence.
// - Host issues identification exit after reading codes.
// - Host polls for completion, then may start next access.
// - Only low data byte carries codes; upper byte zero; A15 ignored.
// - Sequences start with unlock writes AA at 5555, 55 at 2AAA; the single-cycle exit PNF_ID_EXIT1 sends only F0 at the user address.
`timescale 1ns/1ps
module pnfcs_ctrl
  import pnfcs_pkg::*;
#(
  parameter int unsigned POLL_MAX = POLL_LIMIT
)(
  input  wire logic               CLK_I,
  input  wire logic               SRST_I,
  input  wire logic               CE_I,
  input  wire logic               REQ_VALID_I,
  input  wire pnfcs_req_s         REQ_I,
  output logic                    REQ_READY_O,
  output logic                    DONE_O,
  output logic [DATA_W-1:0]       RDATA_O,
  output logic                    TIMEOUT_O,
  output logic                    FLASH_CE_N_O,
  output logic                    FLASH_OE_N_O,
  output logic                    FLASH_WE_N_O,
  output logic [ADDR_W-1:0]       FLASH_A_O,
  output logic [DATA_W-1:0]       FLASH_DQ_O,
  output logic                    FLASH_DQ_OE_O,
  input  wire logic [DATA_W-1:0]  FLASH_DQ_I
);
  typedef struct packed {
    pnfcs_st_e          st;
    pnfcs_req_s         req;
    logic [2:0]         idx;
    logic [2:0]         cnt;
    logic               polling;
    logic               have_prev;
    logic [DATA_W-1:0]  prev;
    logic [19:0]        pwait;
    logic               done;
    logic               tout;
    logic [DATA_W-1:0]  rdata;
    pnfcs_pins_s        pins;
  } pnfcs_state_s;

  pnfcs_state_s s_ff;
  pnfcs_state_s nxt_s;
  logic [2:0]   rom_len;
  logic [15:0]  rom_addr;
  logic [7:0]   rom_code;
  logic         rom_user;

  pnfcs_seq_rom u_rom (
    .CLK_I  (CLK_I),
    .CE_I   (CE_I),
    .OP_I   (nxt_s.req.op),
    .IDX_I  (nxt_s.idx),
    .LEN_O  (rom_len),
    .ADDR_O (rom_addr),
    .CODE_O (rom_code),
    .USER_O (rom_user)
  );

  function automatic logic is_write_op(input pnfcs_op_e op);
    is_write_op = (op != PNF_READ);
  endfunction : is_write_op

  function automatic logic needs_poll(input pnfcs_op_e op);
    needs_poll = (op == PNF_PROGRAM) || (op == PNF_CHIP_ER) ||
                 (op == PNF_MAIN_ER) || (op == PNF_LOCKOUT);
  endfunction : needs_poll

  localparam pnfcs_pins_s PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                        d_oe: 1'b0, a: '0, dq: '0};

  always_comb begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    case (s_ff.st)
      ST_IDLE: begin
        nxt_s.pins = PINS_IDLE;
        if (REQ_VALID_I) begin
          nxt_s.req       = REQ_I;
          nxt_s.idx       = 3'h0;
          nxt_s.cnt       = 3'h0;
          nxt_s.polling   = 1'b0;
          nxt_s.have_prev = 1'b0;
          nxt_s.pwait     = '0;
          nxt_s.tout      = 1'b0;
          nxt_s.st        = is_write_op(REQ_I.op) ? ST_SETUP : ST_RDSET;
        end
      end
      ST_SETUP: begin
        nxt_s.pins.ce_n = 1'b1;
        nxt_s.pins.oe_n = 1'b1;
        nxt_s.pins.we_n = 1'b1;
        nxt_s.pins.d_oe = 1'b1;
        nxt_s.pins.a    = rom_user ? s_ff.req.addr : rom_addr;
        nxt_s.pins.dq   = (rom_user && s_ff.req.op == PNF_PROGRAM) ? s_ff.req.data
                                                                 : {8'h00, rom_code};
        nxt_s.cnt       = 3'h0;
        nxt_s.st        = ST_STRB;
      end
      ST_STRB: begin
        // output drive high, both strobes low
        // strobe held well beyond noise threshold
        nxt_s.pins.ce_n = 1'b0;
        nxt_s.pins.we_n = 1'b0;
        nxt_s.cnt       = s_ff.cnt + 3'h1;
        if (s_ff.cnt == 3'(STROBE_CYC - 1)) begin
          nxt_s.st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        nxt_s.pins.ce_n = 1'b1;
        nxt_s.pins.we_n = 1'b1;
        nxt_s.idx       = s_ff.idx + 3'h1;
        // all cycles of the sequence are sent
        if (s_ff.idx + 3'h1 >= rom_len) begin
          // Data stays driven past the rising strobe; read setup or idle releases it
          // poll status after the final strobe
          if (needs_poll(s_ff.req.op)) begin
            nxt_s.polling = 1'b1;
            nxt_s.st      = ST_RDSET;
          end else begin
            nxt_s.st = ST_DONE;
          end
        end else begin
          nxt_s.st = ST_SETUP;
        end
      end
      ST_RDSET: begin
        nxt_s.pins.d_oe = 1'b0;
        nxt_s.pins.we_n = 1'b1;
        nxt_s.pins.ce_n = 1'b0;
        nxt_s.pins.oe_n = 1'b0;
        nxt_s.pins.a    = s_ff.req.addr;
        nxt_s.cnt       = 3'h0;
        nxt_s.st        = ST_RDSMP;
      end
      ST_RDSMP: begin
        nxt_s.cnt = s_ff.cnt + 3'h1;
        if (s_ff.cnt == 3'(READ_CYC - 1)) begin
          nxt_s.pins.ce_n = 1'b1;
          nxt_s.pins.oe_n = 1'b1;
          nxt_s.rdata     = FLASH_DQ_I;
          nxt_s.prev      = FLASH_DQ_I;
          nxt_s.have_prev = 1'b1;
          nxt_s.st        = ST_DONE;
          if (s_ff.polling) begin
            nxt_s.pwait = s_ff.pwait + 20'h1;
            // toggle bit still moving means busy
            if (s_ff.have_prev &&
                FLASH_DQ_I[TOGGLE_BIT] != s_ff.prev[TOGGLE_BIT]) begin
              nxt_s.st = ST_RDSET;
            end
            // programming busy while bit 7 inverted
            if (s_ff.req.op == PNF_PROGRAM &&
                FLASH_DQ_I[POLL_BIT] != s_ff.req.data[POLL_BIT]) begin
              nxt_s.st = ST_RDSET;
            end
            if (!s_ff.have_prev) begin
              nxt_s.st = ST_RDSET;
            end
            if (s_ff.pwait == 20'(POLL_MAX - 1)) begin
              nxt_s.tout = 1'b1;
              nxt_s.st   = ST_DONE;
            end
          end
        end
      end
      ST_DONE: begin
        nxt_s.pins = PINS_IDLE;
        nxt_s.done = 1'b1;
        nxt_s.st   = ST_IDLE;
      end
      default: begin
        nxt_s.st   = ST_IDLE;
        nxt_s.pins = PINS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      s_ff      <= '0;
      s_ff.st   <= ST_IDLE;
      s_ff.pins <= PINS_IDLE;
    end else if (CE_I) begin
      s_ff <= nxt_s;
    end
  end

  assign REQ_READY_O   = (s_ff.st == ST_IDLE);
  assign DONE_O        = s_ff.done;
  assign RDATA_O       = s_ff.rdata;
  assign TIMEOUT_O     = s_ff.tout;
  assign FLASH_CE_N_O  = s_ff.pins.ce_n;
  assign FLASH_OE_N_O  = s_ff.pins.oe_n;
  assign FLASH_WE_N_O  = s_ff.pins.we_n;
  assign FLASH_A_O     = s_ff.pins.a;
  assign FLASH_DQ_O    = s_ff.pins.dq;
  assign FLASH_DQ_OE_O = s_ff.pins.d_oe;

  //////////////////////////////////////////////////////////////////////////////
  a_wr_no_oe: assert property (@(posedge CLK_I) disable iff (SRST_I)
    !FLASH_WE_N_O |-> FLASH_OE_N_O)
    else $error("write strobe low while output drive low");
  a_rd_bus_free: assert property (@(posedge CLK_I) disable iff (SRST_I)
    !FLASH_OE_N_O |-> !FLASH_DQ_OE_O)
    else $error("data driven during read");
  a_rd_strobes: assert property (@(posedge CLK_I) disable iff (SRST_I)
    !FLASH_OE_N_O |-> !FLASH_CE_N_O && FLASH_WE_N_O)
    else $error("read strobes wrong");
  a_we_width: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && $fell(FLASH_WE_N_O) |-> !FLASH_WE_N_O [*2])
    else $error("write strobe pulse too short");
  a_data_hold: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && $rose(FLASH_WE_N_O) |-> FLASH_DQ_OE_O && $stable(FLASH_DQ_O))
    else $error("data not held past strobe rise");
  a_addr_stable: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && !FLASH_WE_N_O && $past(!FLASH_WE_N_O) |-> $stable(FLASH_A_O))
    else $error("address moved during strobe");
  a_code_upper: assert property (@(posedge CLK_I) disable iff (SRST_I)
    !FLASH_WE_N_O && !(s_ff.req.op == PNF_PROGRAM && s_ff.idx == 3'h3)
    |-> FLASH_DQ_O[15:8] == 8'h00)
    else $error("upper byte not zero in command");
  a_unlock_first: assert property (@(posedge CLK_I) disable iff (SRST_I)
    !FLASH_WE_N_O && s_ff.idx == 3'h0 && s_ff.req.op != PNF_ID_EXIT1
    |-> FLASH_A_O == ADR_UNLK1 && FLASH_DQ_O[7:0] == CD_UNLK1)
    else $error("sequence not opened by unlock write");
  a_ready_idle: assert property (@(posedge CLK_I) disable iff (SRST_I)
    DONE_O |-> REQ_READY_O)
    else $error("not ready after completion");
  c_program: cover property (@(posedge CLK_I) DONE_O && s_ff.req.op == PNF_PROGRAM);
  c_main_erase: cover property (@(posedge CLK_I) DONE_O && s_ff.req.op == PNF_MAIN_ER);
  c_read: cover property (@(posedge CLK_I) DONE_O && s_ff.req.op == PNF_READ);
  c_id_exit: cover property (@(posedge CLK_I) DONE_O && s_ff.req.op == PNF_ID_EXIT1);
endmodule : pnfcs_ctrl

// ===== sim/pnfcs_flash_model.sv
// Behavioural model of the parallel NOR flash seen by the host controller
`timescale 1ns/1ps
module pnfcs_flash_model
  import pnfcs_pkg::*;
#(
  parameter int          BUSY_RD = 3,
  // Identity values are arbitrary
  parameter logic [15:0] MFG_ID  = 16'h00A5,
  parameter logic [15:0] DEV_ID  = 16'h005A
)(
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [15:0] a_i,
  input  wire logic [15:0] d_i,
  output logic      [15:0] dq_o
);
  logic [15:0] mem [0:65535];
  logic [15:0] la, lv, dv, ld;
  logic [2:0]  st;
  logic [7:0]  pre;
  logic        lk, idm, tog, pg;
  int          busy;
  realtime     tf;
  wire         wr = ce_n_i | we_n_i;
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = i[15:0] ^ 16'h3C3C;
    {st, pre, lk, idm, tog, pg, ld, lv} = '0;
    busy = 0;
    tf = 0;
  end
  ////////////////////////////////////////////////////////////////////////
  // address on later falling edge
  always @(negedge wr) begin
    la = a_i;
    tf = $realtime;
  end
  // data on earlier rise, short pulses dropped
  always @(posedge wr) if (oe_n_i && $realtime - tf >= GLITCH_NS && busy == 0) cmd(la, d_i);
  task automatic erase(input logic chip);
    // boot kept when locked or main only
    for (int i = 0; i < 65536; i++) if (i > BOOT_LAST || (chip && !lk)) mem[i] = ERASED_WORD;
    pg = 1'b0;
    busy = BUSY_RD;
  endtask : erase
  task automatic cmd(input logic [15:0] a, input logic [15:0] d);
    logic u1, u2;
    u1 = a[14:0] == ADR_UNLK1[14:0];
    u2 = a[14:0] == ADR_UNLK2[14:0];
    if (st == 3 && pre == CD_PROG) begin
      if (!(lk && a <= BOOT_LAST)) mem[a] = mem[a] & d;
      lv = d;
      pg = 1'b1;
      busy = BUSY_RD;
      st = 0;
    end else if (st == 0 && d[7:0] == CD_ID_EXIT) idm = 1'b0;
    else if ((st == 0 || st == 3) && u1 && d[7:0] == CD_UNLK1) st++;
    else if ((st == 1 || st == 4) && u2 && d[7:0] == CD_UNLK2) st++;
    else if (st == 2 && u1 && d[7:0] inside {CD_PROG, CD_ERASE_PRE}) begin
      pre = d[7:0];
      st = 3;
    end else if (st == 2 && u1 && d[7:0] inside {CD_ID_ENTRY, CD_ID_EXIT}) begin
      idm = d[7:0] == CD_ID_ENTRY;
      st = 0;
    end else if (st == 5 && u1 && pre == CD_ERASE_PRE) begin
      if (d[7:0] == CD_CHIP) erase(1'b1);
      if (d[7:0] == CD_MAIN) erase(1'b0);
      if (d[7:0] == CD_LOCK) lk = 1'b1;
      st = 0;
    end else st = 0;
  endtask : cmd
  ////////////////////////////////////////////////////////////////////////
  // status and identification words
  always @* begin
    dv = mem[a_i];
    if (idm) dv = a_i == 0 ? MFG_ID : a_i == 1 ? DEV_ID : a_i == ADR_LOCK_STAT ? {15'h0, lk} : dv;
    if (busy > 0) begin
      dv[POLL_BIT] = pg ? ~lv[POLL_BIT] : 1'b0;
      dv[TOGGLE_BIT] = tog;
    end
  end
  // released bus shows the inverse so stale data cannot pass
  assign dq_o = (!ce_n_i && !oe_n_i && we_n_i) ? dv : ~ld;
  // each read ends one busy step
  always @(posedge oe_n_i) begin
    ld = dv;
    if (busy > 0) begin
      busy--;
      tog = ~tog;
    end
  end
endmodule : pnfcs_flash_model

// ===== sim/tb_top.sv
// Self-checking bench for the flash host controller against the flash model
`timescale 1ns/1ps
module tb_top
  import pnfcs_pkg::*;
;
  // Identity values are arbitrary
  localparam logic [15:0] MFG = 16'h00A5;
  localparam logic [15:0] DEV = 16'h005A;
  logic        clk = 1'b0, srst = 1'b1, vld = 1'b0, ce = 1'b1;
  pnfcs_req_s  req = '0;
  logic        rdy, done, tmo, ce_n, oe_n, we_n, doe;
  logic [15:0] rdata, fa, fdo, mdq, fdi;
  int          fail_count = 0, n_compared = 0;
  always #12.5 clk = ~clk;
  assign fdi = doe ? fdo : mdq;
  pnfcs_ctrl #(.POLL_MAX(50)) DUT (
    .CLK_I(clk), .SRST_I(srst), .CE_I(ce), .REQ_VALID_I(vld), .REQ_I(req),
    .REQ_READY_O(rdy), .DONE_O(done), .RDATA_O(rdata), .TIMEOUT_O(tmo),
    .FLASH_CE_N_O(ce_n), .FLASH_OE_N_O(oe_n), .FLASH_WE_N_O(we_n), .FLASH_A_O(fa),
    .FLASH_DQ_O(fdo), .FLASH_DQ_OE_O(doe), .FLASH_DQ_I(fdi));
  pnfcs_flash_model #(.MFG_ID(MFG), .DEV_ID(DEV)) u_flash (
    .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .a_i(fa), .d_i(fdi), .dq_o(mdq));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("compared=%0d failed=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic stuck();
    fail_count++;
    give_verdict();
  endtask : stuck
  task automatic run(input pnfcs_op_e o, input logic [15:0] a, input logic [15:0] d);
    int n;
    @(posedge clk);
    req <= '{o, a, d};
    vld <= 1'b1;
    @(negedge clk);
    for (n = 0; rdy !== 1'b1; n++) begin
      if (n > 99) stuck();
      @(negedge clk);
    end
    @(posedge clk);
    vld <= 1'b0;
    for (n = 0; done !== 1'b1; n++) begin
      if (n > 3000) stuck();
      @(negedge clk);
    end
  endtask : run
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    run(PNF_READ, a, 16'h0000);
    chk(rdata, exp);
  endtask : rd
  // reads keep the write strobe high and the host off the bus
  always @(negedge clk) if (!oe_n) chk(16'({we_n, doe}), 16'h0002);
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk(16'({ce_n, oe_n, we_n, doe}), 16'h000E);
    run(PNF_CHIP_ER, 16'h0000, 16'h0000);
    rd(16'h0010, ERASED_WORD);
    rd(16'hC000, ERASED_WORD);
    // Clock enable low must freeze a read in mid-access
    @(posedge clk);
    req <= '{PNF_READ, 16'hC000, 16'h0000};
    vld <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
    repeat (2) @(posedge clk);
    ce <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk(16'({ce_n, oe_n, done}), 16'h0000);
    @(posedge clk);
    ce <= 1'b1;
    for (int n = 0; done !== 1'b1; n++) begin
      if (n > 99) stuck();
      @(negedge clk);
    end
    chk(rdata, ERASED_WORD);
    run(PNF_PROGRAM, 16'h0100, 16'h0F5A);
    chk(rdata, 16'h0F5A);
    chk(16'(tmo), 16'h0000);
    run(PNF_PROGRAM, 16'h0100, 16'hF0F0);
    rd(16'h0100, 16'h0050);
    run(PNF_ID_ENTRY, 16'h0000, 16'h0000);
    rd(16'h0000, MFG);
    rd(16'h0001, DEV);
    rd(16'h0002, 16'h0000);
    run(PNF_ID_EXIT1, 16'h1234, 16'h0000);
    rd(16'h0002, ERASED_WORD);
    run(PNF_LOCKOUT, 16'h0000, 16'h0000);
    run(PNF_ID_ENTRY, 16'h0000, 16'h0000);
    rd(16'h0002, 16'h0001);
    run(PNF_ID_EXIT, 16'h0000, 16'h0000);
    rd(16'h0002, ERASED_WORD);
    run(PNF_PROGRAM, 16'h0100, 16'h0000);
    rd(16'h0100, 16'h0050);
    // Locked word never shows the polled bit, so polling must give up
    run(PNF_PROGRAM, 16'h1FFF, 16'h0000);
    chk(16'(tmo), 16'h0001);
    rd(16'h1FFF, ERASED_WORD);
    run(PNF_PROGRAM, 16'h2000, 16'h1234);
    rd(16'h2000, 16'h1234);
    run(PNF_MAIN_ER, 16'h0000, 16'h0000);
    rd(16'h2000, ERASED_WORD);
    rd(16'h0100, 16'h0050);
    run(PNF_PROGRAM, 16'hA000, 16'h00FF);
    run(PNF_CHIP_ER, 16'h0000, 16'h0000);
    rd(16'hA000, ERASED_WORD);
    rd(16'h0100, 16'h0050);
    give_verdict();
  end
endmodule : tb_top
